/* design/acs_pkg.sv */
// Shared timing constants for the conversion and reset sequencer
package acs_pkg;

  // ********************************************************
  // Clock and widths
  // ********************************************************
  localparam int CLK_NS = 10;
  localparam int SEL_W  = 3;
  localparam int CNT_W  = 24;

  // ********************************************************
  // Times as printed
  // ********************************************************
  localparam int T_CONV_NS       = 475;
  localparam int T_CONV_MAX_NS   = 530;
  localparam int T_ACQ_NS        = 470;
  localparam int T_CYCLE_US      = 1;
  localparam int T_CONV_LOW_NS   = 50;
  localparam int T_CONV_HIGH_NS  = 50;
  localparam int T_BUSY_DLY_NS   = 34;
  localparam int T_CS_SETUP_NS   = 20;
  localparam int T_QUIET_NS      = 50;
  localparam int T_PRST_MIN_NS   = 40;
  localparam int T_PRST_MAX_NS   = 500;
  localparam int T_FRST_NS       = 1200;
  localparam int T_PCONV_NS      = 120;
  localparam int T_FCONV_MS      = 15;
  localparam int T_PWRITE_NS     = 50;
  localparam int T_FWRITE_US     = 240;
  localparam int T_RST_WAIT_MS   = 1;
  localparam int T_PHW_SETUP_NS  = 10;
  localparam int T_FHW_SETUP_US  = 50;
  localparam int T_PHW_HOLD_NS   = 10;
  localparam int T_FHW_HOLD_US   = 240;

  // ********************************************************
  // Cycle counts; least times round up, longest round down
  // ********************************************************
  localparam int CONV_CYC      = T_CONV_NS / CLK_NS;
  localparam int CONV_MAX_CYC  = T_CONV_MAX_NS / CLK_NS;
  localparam int ACQ_CYC       = (T_ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_CYC     = (T_CYCLE_US * 1000) / CLK_NS;
  localparam int CONV_LOW_CYC  = (T_CONV_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_HIGH_CYC = (T_CONV_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_DLY_CYC  = T_BUSY_DLY_NS / CLK_NS;
  localparam int CS_SETUP_CYC  = (T_CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int QUIET_CYC     = (T_QUIET_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRST_MIN_CYC  = (T_PRST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRST_MAX_CYC  = T_PRST_MAX_NS / CLK_NS;
  localparam int FRST_CYC      = (T_FRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int PCONV_CYC     = (T_PCONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int FCONV_CYC     = (T_FCONV_MS * 1000000) / CLK_NS;
  localparam int PWRITE_CYC    = (T_PWRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FWRITE_CYC    = (T_FWRITE_US * 1000) / CLK_NS;
  localparam int RST_WAIT_CYC  = (T_RST_WAIT_MS * 1000000) / CLK_NS;
  localparam int PHW_SETUP_CYC = (T_PHW_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FHW_SETUP_CYC = (T_FHW_SETUP_US * 1000) / CLK_NS;
  localparam int PHW_HOLD_CYC  = (T_PHW_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FHW_HOLD_CYC  = (T_FHW_HOLD_US * 1000) / CLK_NS;

  // ********************************************************
  // Host commands
  // ********************************************************
  typedef enum logic [2:0] {
    ACS_CMD_CONVERT = 3'h0,
    ACS_CMD_READ    = 3'h1,
    ACS_CMD_WRITE   = 3'h2,
    ACS_CMD_PRESET  = 3'h3,
    ACS_CMD_FRESET  = 3'h4
  } acs_cmd_t;

endpackage

/* design/acs_link_if.sv */
// Pin-level link between the converter and its host
`timescale 1ns/1ps
interface acs_link_if
  import acs_pkg::*;
();
  logic             conversion_start_strobe;
  logic             cs_n;
  logic             reset_n;
  logic [SEL_W-1:0] channel_pair_select;
  logic             busy;

  modport dev (
    input  conversion_start_strobe,
    input  cs_n,
    input  reset_n,
    input  channel_pair_select,
    output busy
  );

  modport host (
    output conversion_start_strobe,
    output cs_n,
    output reset_n,
    output channel_pair_select,
    input  busy
  );
endinterface

/* design/acs_dev.sv */
// Converter end: busy timing and reset width classification
`timescale 1ns/1ps
module acs_dev
  import acs_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  acs_link_if.dev               link,
  output logic                  sample_pulse,
  output logic                  result_valid,
  output logic [SEL_W-1:0]      sel_latched,
  output logic                  part_reset_pulse,
  output logic                  full_reset_pulse,
  output logic                  in_reset
);

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic             stb_s1_reg, stb_s2_reg, stb_s3_reg;
  logic             rn_s1_reg, rn_s2_reg;
  logic [SEL_W-1:0] sel_s1_reg, sel_s2_reg;
  logic [7:0]       low_cnt_reg;
  logic [7:0]       conv_cnt_reg;
  logic             busy_reg;
  logic             stb_rise;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stb_s1_reg <= 1'b0;
      stb_s2_reg <= 1'b0;
      stb_s3_reg <= 1'b0;
      rn_s1_reg  <= 1'b0;
      rn_s2_reg  <= 1'b0;
      sel_s1_reg <= '0;
      sel_s2_reg <= '0;
    end else begin
      stb_s1_reg <= link.conversion_start_strobe;
      stb_s2_reg <= stb_s1_reg;
      stb_s3_reg <= stb_s2_reg;
      rn_s1_reg  <= link.reset_n;
      rn_s2_reg  <= rn_s1_reg;
      sel_s1_reg <= link.channel_pair_select;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  assign stb_rise = stb_s2_reg & ~stb_s3_reg;

  // ********************************************************
  // Reset width measurement
  // ********************************************************
  // partial and full reset windows
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_cnt_reg      <= 8'h00;
      part_reset_pulse <= 1'b0;
      full_reset_pulse <= 1'b0;
      sel_latched      <= '0;
      in_reset         <= 1'b1;
    end else begin
      part_reset_pulse <= 1'b0;
      full_reset_pulse <= 1'b0;
      in_reset         <= ~rn_s2_reg;
      if (!rn_s2_reg) begin
        if (low_cnt_reg != 8'hFF)
          low_cnt_reg <= low_cnt_reg + 8'h01;
      end else if (low_cnt_reg != 8'h00) begin
        low_cnt_reg <= 8'h00;
        // Too short to count as any reset: glitch ignored
        if (low_cnt_reg >= 8'(PRST_MIN_CYC)) begin
          sel_latched <= sel_s2_reg;
          // Widths between the two windows taken as full: safer
          if (low_cnt_reg > 8'(PRST_MAX_CYC))
            full_reset_pulse <= 1'b1;
          else
            part_reset_pulse <= 1'b1;
        end
      end
    end
  end

  // ********************************************************
  // Conversion timing
  // ********************************************************
  // busy within delay
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_reg     <= 1'b0;
      conv_cnt_reg <= 8'h00;
      sample_pulse <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      sample_pulse <= 1'b0;
      result_valid <= 1'b0;
      if (!rn_s2_reg) begin
        busy_reg     <= 1'b0;
        conv_cnt_reg <= 8'h00;
      end else if (!busy_reg && stb_rise) begin
        busy_reg     <= 1'b1;
        sample_pulse <= 1'b1;
        conv_cnt_reg <= 8'h01;
      end else if (busy_reg) begin
        if (conv_cnt_reg >= 8'(CONV_CYCLES)) begin
          busy_reg     <= 1'b0;
          result_valid <= 1'b1;
        end else begin
          conv_cnt_reg <= conv_cnt_reg + 8'h01;
        end
      end
    end
  end

  assign link.busy = busy_reg;

endmodule

/* design/acs_host.sv */
// Host end: paces conversion, reads, writes and resets
`timescale 1ns/1ps
module acs_host
  import acs_pkg::*;
#(
  parameter int RD_CYCLES  = 4,
  parameter int WR_CYCLES  = 4,
  parameter int PWR_WAIT   = RST_WAIT_CYC,
  parameter int FULL_CONV  = FCONV_CYC,
  parameter int FULL_WRITE = FWRITE_CYC,
  parameter int FULL_SETUP = FHW_SETUP_CYC,
  parameter int FULL_HOLD  = FHW_HOLD_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  acs_link_if.host              link,
  input  wire logic             power_stable,
  input  wire logic             cmd_valid,
  input  wire acs_cmd_t         cmd,
  input  wire logic [SEL_W-1:0] cmd_sel,
  output logic                  cmd_ready,
  output logic                  conv_done,
  output logic                  read_done,
  output logic                  write_done,
  output logic                  reset_done
);

  // ********************************************************
  // State and timers
  // ********************************************************
  typedef enum logic [6:0] {
    ST_PWR  = 7'h01,
    ST_RST  = 7'h02,
    ST_IDLE = 7'h04,
    ST_CHI  = 7'h08,
    ST_CLO  = 7'h10,
    ST_RD   = 7'h20,
    ST_WR   = 7'h40
  } acs_hst_t;

  // Full low time also covers config setup before release
  localparam int FULL_LOW =
    (FRST_CYC > FULL_SETUP) ? FRST_CYC : FULL_SETUP;

  acs_hst_t         state_reg;
  logic [CNT_W-1:0] st_cnt_reg, rise_cnt_reg, fall_cnt_reg;
  logic [CNT_W-1:0] csr_cnt_reg, rel_cnt_reg;
  logic             full_reg, busy_seen_reg, unread_reg;
  logic             busy_s1_reg, busy_s2_reg, busy_s3_reg;
  logic             stb_reg, cs_n_reg, rn_reg;
  logic [SEL_W-1:0] sel_reg;
  logic             take, busy_fall;
  logic             ok_conv, ok_read, ok_write, ok_reset, ok_cmd;

  function automatic logic [CNT_W-1:0] sat_inc(
    input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  function automatic logic reached(input logic [CNT_W-1:0] v,
                                   input int lim);
    reached = v >= CNT_W'(lim);
  endfunction

  // ********************************************************
  // Busy synchroniser
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
      busy_s3_reg <= 1'b0;
    end else begin
      busy_s1_reg <= link.busy;
      busy_s2_reg <= busy_s1_reg;
      busy_s3_reg <= busy_s2_reg;
    end
  end

  assign busy_fall = busy_s3_reg & ~busy_s2_reg;

  // ********************************************************
  // Spacing gates
  // ********************************************************
  always_comb begin
    ok_conv = reached(rise_cnt_reg, CYCLE_CYC)
            & reached(fall_cnt_reg, ACQ_CYC)
            & reached(csr_cnt_reg, QUIET_CYC)
            & reached(rel_cnt_reg, full_reg ? FULL_CONV : PCONV_CYC)
            & ~busy_s2_reg;
    ok_read = unread_reg & ~busy_s2_reg
            & reached(fall_cnt_reg, CS_SETUP_CYC);
    ok_write = ~busy_s2_reg & reached(csr_cnt_reg, 1)
             & reached(rel_cnt_reg, full_reg ? FULL_WRITE : PWRITE_CYC);
    ok_reset = ~busy_s2_reg
             & reached(rel_cnt_reg, full_reg ? FULL_HOLD : PHW_HOLD_CYC);
    case (cmd)
      ACS_CMD_CONVERT: ok_cmd = ok_conv;
      ACS_CMD_READ:    ok_cmd = ok_read;
      ACS_CMD_WRITE:   ok_cmd = ok_write;
      ACS_CMD_PRESET:  ok_cmd = ok_reset;
      ACS_CMD_FRESET:  ok_cmd = ok_reset;
      default:         ok_cmd = 1'b0;
    endcase
  end

  assign take = cmd_valid & cmd_ready;

  // Ready needs valid: a stale ready must not take a new command
  always_ff @(posedge sys_clk) begin
    if (rst)
      cmd_ready <= 1'b0;
    else
      cmd_ready <= (state_reg == ST_IDLE) & ok_cmd & cmd_valid & ~take;
  end

  // ********************************************************
  // Timers
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rise_cnt_reg <= '1;
      fall_cnt_reg <= '1;
      csr_cnt_reg  <= '1;
      rel_cnt_reg  <= '0;
    end else begin
      rise_cnt_reg <= (state_reg == ST_CHI && st_cnt_reg == '0)
                    ? '0 : sat_inc(rise_cnt_reg);
      fall_cnt_reg <= busy_fall ? '0 : sat_inc(fall_cnt_reg);
      csr_cnt_reg  <= !cs_n_reg ? '0 : sat_inc(csr_cnt_reg);
      rel_cnt_reg  <= !rn_reg ? '0 : sat_inc(rel_cnt_reg);
    end
  end

  // ********************************************************
  // Sequencer
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg  <= ST_PWR;
      st_cnt_reg <= '0;
      full_reg   <= 1'b1;
      sel_reg    <= '0;
    end else begin
      st_cnt_reg <= sat_inc(st_cnt_reg);
      case (state_reg)
        ST_PWR: begin
          if (!power_stable)
            st_cnt_reg <= '0;
          else if (reached(st_cnt_reg, PWR_WAIT)) begin
            state_reg  <= ST_IDLE;
            st_cnt_reg <= '0;
          end
        end
        ST_RST: begin
          if (reached(st_cnt_reg,
                      full_reg ? FULL_LOW : PRST_MIN_CYC - 1)) begin
            state_reg  <= ST_IDLE;
            st_cnt_reg <= '0;
          end
        end
        ST_IDLE: begin
          st_cnt_reg <= '0;
          if (take) begin
            case (cmd)
              ACS_CMD_CONVERT: state_reg <= ST_CHI;
              ACS_CMD_READ:    state_reg <= ST_RD;
              ACS_CMD_WRITE:   state_reg <= ST_WR;
              ACS_CMD_PRESET, ACS_CMD_FRESET: begin
                state_reg <= ST_RST;
                full_reg  <= (cmd == ACS_CMD_FRESET);
                sel_reg   <= cmd_sel;
              end
              default:         state_reg <= ST_IDLE;
            endcase
          end
        end
        ST_CHI: begin
          if (reached(st_cnt_reg, CONV_HIGH_CYC - 1)) begin
            state_reg  <= ST_CLO;
            st_cnt_reg <= '0;
          end
        end
        ST_CLO: begin
          if (busy_seen_reg && !busy_s2_reg
              && reached(st_cnt_reg, CONV_LOW_CYC - 1))
            state_reg <= ST_IDLE;
        end
        ST_RD: begin
          if (reached(st_cnt_reg, RD_CYCLES - 1))
            state_reg <= ST_IDLE;
        end
        ST_WR: begin
          if (reached(st_cnt_reg, WR_CYCLES - 1))
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_PWR;
      endcase
    end
  end

  // ********************************************************
  // Pins and result flags
  // ********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_seen_reg <= 1'b0;
      unread_reg    <= 1'b0;
    end else begin
      if (state_reg == ST_CHI)
        busy_seen_reg <= 1'b0;
      else if (busy_s2_reg)
        busy_seen_reg <= 1'b1;
      // Set wins over clear by ordering
      if (state_reg == ST_RD || state_reg == ST_RST)
        unread_reg <= 1'b0;
      if (busy_fall)
        unread_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stb_reg    <= 1'b0;
      cs_n_reg   <= 1'b1;
      rn_reg     <= 1'b0;
      conv_done  <= 1'b0;
      read_done  <= 1'b0;
      write_done <= 1'b0;
      reset_done <= 1'b0;
    end else begin
      stb_reg    <= (state_reg == ST_CHI);
      cs_n_reg   <= ~(state_reg == ST_RD || state_reg == ST_WR);
      rn_reg     <= ~(state_reg == ST_PWR || state_reg == ST_RST);
      conv_done  <= (state_reg == ST_CLO) & busy_seen_reg
                  & ~busy_s2_reg & reached(st_cnt_reg, CONV_LOW_CYC - 1);
      read_done  <= (state_reg == ST_RD)
                  & reached(st_cnt_reg, RD_CYCLES - 1);
      write_done <= (state_reg == ST_WR)
                  & reached(st_cnt_reg, WR_CYCLES - 1);
      reset_done <= (state_reg == ST_IDLE) & ~rn_reg;
    end
  end

  assign link.conversion_start_strobe = stb_reg;
  assign link.cs_n                    = cs_n_reg;
  assign link.reset_n                 = rn_reg;
  assign link.channel_pair_select     = sel_reg;

endmodule

/* dv/acs_props.sv */
// Link checker for the conversion and reset sequencer
`timescale 1ns/1ps
module acs_props
  import acs_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int FULL_CONV   = FCONV_CYC
) (
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic             conversion_start_strobe,
  input wire logic             cs_n,
  input wire logic             reset_n,
  input wire logic [SEL_W-1:0] channel_pair_select,
  input wire logic             busy
);
  // ********************************************************
  // Elapsed-cycle helpers
  // ********************************************************
  // Saturate so long idle spans never wrap to a small count
  logic [CNT_W-1:0] rise_reg, bfall_reg, csh_reg, rel_reg, low_reg, blen_reg;
  logic             full_reg;

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
    return (&v) ? v : v + 24'h000001;
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  always_ff @(posedge sys_clk) begin
    if (rst) rise_reg <= '1;
    else if ($rose(conversion_start_strobe)) rise_reg <= 24'h000001;
    else rise_reg <= bump(rise_reg);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) bfall_reg <= '1;
    else if ($fell(busy)) bfall_reg <= 24'h000001;
    else bfall_reg <= bump(bfall_reg);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) csh_reg <= '1;
    else if ($rose(cs_n)) csh_reg <= 24'h000001;
    else csh_reg <= bump(csh_reg);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) rel_reg <= '1;
    else if ($rose(reset_n)) rel_reg <= 24'h000001;
    else rel_reg <= bump(rel_reg);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) low_reg <= '0;
    else if (!reset_n) low_reg <= bump(low_reg);
    else low_reg <= '0;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) blen_reg <= '0;
    else if (busy) blen_reg <= bump(blen_reg);
    else blen_reg <= '0;
  end
  // Power-up counts as a full reset for the following waits
  always_ff @(posedge sys_clk) begin
    if (rst) full_reg <= 1'b1;
    else if ($rose(reset_n)) full_reg <= (low_reg > PRST_MAX_CYC);
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  a_busy_rise_delay: assert property (
    $rose(conversion_start_strobe) && reset_n && !busy |-> ##[1:3] busy)
    else $error("busy late after start");
  a_conv_busy_width: assert property (
    $fell(busy) && reset_n |-> blen_reg == CONV_CYCLES)
    else $error("busy width wrong");
  a_start_spacing: assert property (
    $rose(conversion_start_strobe) |-> rise_reg >= CYCLE_CYC)
    else $error("start edges too close");
  a_start_high_width: assert property (
    $rose(conversion_start_strobe) |-> conversion_start_strobe [*5])
    else $error("start high too short");
  a_start_low_width: assert property (
    $fell(conversion_start_strobe) |-> !conversion_start_strobe [*5])
    else $error("start low too short");
  a_acq_time_kept: assert property (
    $rose(conversion_start_strobe) |-> bfall_reg >= ACQ_CYC)
    else $error("acquisition too short");
  a_cs_after_busy: assert property (
    $fell(cs_n) |-> !busy && bfall_reg >= CS_SETUP_CYC)
    else $error("select too soon after busy");
  a_quiet_before_start: assert property (
    $rose(conversion_start_strobe) |-> csh_reg >= QUIET_CYC)
    else $error("start too soon after select");
  a_reset_pulse_width: assert property (
    $rose(reset_n) |-> (low_reg >= PRST_MIN_CYC && low_reg <= PRST_MAX_CYC)
      || low_reg >= FRST_CYC)
    else $error("reset width in no class");
  a_release_to_start: assert property (
    $rose(conversion_start_strobe) |->
      rel_reg >= (full_reg ? FULL_CONV : PCONV_CYC))
    else $error("start too soon after reset");
  a_select_hold_reset: assert property (
    $changed(channel_pair_select) |-> ##[0:2] !reset_n)
    else $error("select moved outside reset");

  c_conversion: cover property ($fell(busy));
  c_access: cover property ($rose(cs_n));
  c_part_reset: cover property ($rose(reset_n) && low_reg <= PRST_MAX_CYC);
  c_full_reset: cover property ($rose(reset_n) && low_reg >= FRST_CYC);
endmodule

/* dv/adc_conversion_reset_sequencer_tb_top.sv */
// Testbench joining host and converter ends over the link
`timescale 1ns/1ps
module adc_conversion_reset_sequencer_tb_top
  import acs_pkg::*;
;
  logic             sys_clk      = 1'b0;
  logic             rst          = 1'b1;
  logic             power_stable = 1'b0;
  logic             cmd_valid    = 1'b0;
  acs_cmd_t         cmd          = ACS_CMD_CONVERT;
  logic [SEL_W-1:0] cmd_sel      = 3'h0;
  logic             cmd_ready, conv_done, read_done, write_done, reset_done;
  logic             sample_pulse, result_valid, in_reset;
  logic             part_reset_pulse, full_reset_pulse;
  logic [SEL_W-1:0] sel_latched;
  int               num_errors = 0;
  int               checked    = 0;
  int cyc = 0, rel_cyc, st_cyc, csf_cyc, csr_cyc, bf_cyc, ps_cyc;
  int low_n, bl, cl, sh, lc = 0, bc = 0, cc = 0, sc = 0, rv_n, sp_n;
  bit part_seen, full_seen;
  logic st_d = 1'b0, cs_d = 1'b1, rn_d = 1'b0, b_d = 1'b0, ps_d = 1'b0;

  acs_link_if link ();
  acs_host #(.PWR_WAIT(20), .FULL_CONV(300), .FULL_WRITE(150),
    .FULL_HOLD(150)) acs_host_inst (
    .sys_clk(sys_clk), .rst(rst), .link(link), .power_stable(power_stable),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_sel(cmd_sel),
    .cmd_ready(cmd_ready), .conv_done(conv_done), .read_done(read_done),
    .write_done(write_done), .reset_done(reset_done));
  acs_dev acs_dev_inst (
    .sys_clk(sys_clk), .rst(rst), .link(link), .sample_pulse(sample_pulse),
    .result_valid(result_valid), .sel_latched(sel_latched),
    .part_reset_pulse(part_reset_pulse),
    .full_reset_pulse(full_reset_pulse), .in_reset(in_reset));
  acs_props #(.FULL_CONV(300)) acs_props_inst (
    .sys_clk(sys_clk), .rst(rst),
    .conversion_start_strobe(link.conversion_start_strobe),
    .cs_n(link.cs_n), .reset_n(link.reset_n),
    .channel_pair_select(link.channel_pair_select), .busy(link.busy));

  always #5 sys_clk = ~sys_clk;

  // ********************************************************
  // Link monitor: edge times and pulse widths in cycles
  // ********************************************************
  always @(posedge sys_clk) begin
    cyc++;
    if (power_stable && !ps_d) ps_cyc = cyc;
    if (!link.reset_n) lc++;
    else if (!rn_d) begin
      low_n = lc; lc = 0; rel_cyc = cyc;
    end
    if (link.busy) bc++;
    else if (b_d) begin
      bl = bc; bc = 0; bf_cyc = cyc;
    end
    if (!link.cs_n && cs_d) csf_cyc = cyc;
    if (!link.cs_n) cc++;
    else if (!cs_d) begin
      cl = cc; cc = 0; csr_cyc = cyc;
    end
    if (link.conversion_start_strobe && !st_d) st_cyc = cyc;
    if (link.conversion_start_strobe) sc++;
    else if (st_d) begin
      sh = sc; sc = 0;
    end
    if (part_reset_pulse === 1'b1) part_seen = 1;
    if (full_reset_pulse === 1'b1) full_seen = 1;
    if (result_valid === 1'b1) rv_n++;
    if (sample_pulse === 1'b1) sp_n++;
    {ps_d, rn_d, b_d, cs_d, st_d} = {power_stable, link.reset_n, link.busy,
      link.cs_n, link.conversion_start_strobe};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: %s got %0d", $time, m, got);
    end
  endtask

  function automatic logic done_of(input acs_cmd_t c);
    case (c)
      ACS_CMD_CONVERT: return conv_done;
      ACS_CMD_READ:    return read_done;
      ACS_CMD_WRITE:   return write_done;
      ACS_CMD_PRESET,
      ACS_CMD_FRESET:  return reset_done;
      default:         return 1'b0;
    endcase
  endfunction

  // Offer one command, wait for the take, then for its done pulse
  task automatic do_cmd(input acs_cmd_t c, input logic [SEL_W-1:0] s,
                        input int lim, output bit ok);
    int n;
    ok = 0;
    n = 0;
    part_seen = 0; full_seen = 0; rv_n = 0; sp_n = 0;
    cmd <= c;
    cmd_sel <= s;
    cmd_valid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < lim);
    cmd_valid <= 1'b0;
    if (cmd_ready !== 1'b1) return;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (done_of(c) !== 1'b1 && n < 6000);
    ok = (done_of(c) === 1'b1);
    // Device pulses trail the release by a few cycles
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("wrong value at %0t ns: run hung", $time);
    close_out();
  end

  initial begin
    bit ok;
    int prev;
    repeat (4) @(posedge sys_clk);
    chk(in_reset, 1'b1, "in_reset during rst");
    rst <= 1'b0;
    repeat (150) @(posedge sys_clk);
    chk(link.reset_n, 1'b0, "released without power");
    power_stable <= 1'b1;
    for (int i = 0; i < 200 && reset_done !== 1'b1; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk(rel_cyc - ps_cyc >= 20, 1, "power wait");
    chk(full_seen, 1, "power-up full reset");
    chk(in_reset, 1'b0, "in_reset after release");
    $display("test power_up done");
    do_cmd(ACS_CMD_CONVERT, 3'h0, 1000, ok);
    chk(ok, 1, "convert");
    chk(st_cyc - rel_cyc >= 300, 1, "start after full");
    chk(bl, CONV_CYC, "busy width");
    chk(sh, CONV_HIGH_CYC, "strobe high width");
    chk(sp_n, 1, "sample pulses");
    chk(rv_n, 1, "result pulses");
    prev = st_cyc;
    do_cmd(ACS_CMD_CONVERT, 3'h0, 1000, ok);
    chk(st_cyc - prev >= CYCLE_CYC, 1, "start spacing");
    $display("test convert done");
    do_cmd(ACS_CMD_READ, 3'h0, 200, ok);
    chk(ok, 1, "read");
    chk(cl, 4, "read select width");
    chk(csf_cyc - bf_cyc >= CS_SETUP_CYC, 1, "select after busy");
    do_cmd(ACS_CMD_READ, 3'h0, 200, ok);
    chk(ok, 0, "read without result");
    do_cmd(acs_cmd_t'(3'h7), 3'h0, 50, ok);
    chk(ok, 0, "bad command");
    $display("test read done");
    do_cmd(ACS_CMD_PRESET, 3'h5, 500, ok);
    chk(low_n, PRST_MIN_CYC, "partial low width");
    chk(part_seen, 1, "partial class");
    chk(sel_latched, 3'h5, "select latched");
    do_cmd(ACS_CMD_WRITE, 3'h0, 500, ok);
    chk(csf_cyc - rel_cyc >= PWRITE_CYC, 1, "write after partial");
    do_cmd(ACS_CMD_CONVERT, 3'h0, 1000, ok);
    chk(st_cyc - rel_cyc >= PCONV_CYC, 1, "start after partial");
    chk(st_cyc - csr_cyc >= QUIET_CYC, 1, "quiet before start");
    $display("test partial_reset done");
    do_cmd(ACS_CMD_FRESET, 3'h2, 2000, ok);
    chk(low_n, FHW_SETUP_CYC + 1, "full low width");
    chk(full_seen, 1, "full class");
    chk(sel_latched, 3'h2, "select latched");
    do_cmd(ACS_CMD_WRITE, 3'h0, 1000, ok);
    chk(ok, 1, "write");
    chk(csf_cyc - rel_cyc >= 150, 1, "write after full");
    do_cmd(ACS_CMD_CONVERT, 3'h0, 1000, ok);
    chk(st_cyc - rel_cyc >= 300, 1, "start after full");
    $display("test full_reset done");
    close_out();
  end
endmodule
